// File: hdl/isr_params.svh
// constants of the instrument status reporting block
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH
`define ISR_ERR_DEPTH      20
`define ISR_ERR_CHARS      80
`define ISR_ESR_OPC        0
`define ISR_ESR_QYE        2
`define ISR_ESR_DDE        3
`define ISR_ESR_EXE        4
`define ISR_ESR_CME        5
`define ISR_ESR_PON        7
`define ISR_ESR_VALID      8'hbd
`define ISR_QUES_VOLT      0
`define ISR_QUES_CURR      1
`define ISR_QUES_OHMS      9
`define ISR_QUES_LO        11
`define ISR_QUES_HI        12
`define ISR_QUES_VALID     16'h1a03
`define ISR_STB_QUES       3
`define ISR_STB_MAV        4
`define ISR_STB_ESB        5
`define ISR_STB_RQS        6
`define ISR_STB_EAV        2
`define ISR_MASK_RST8      8'h00
`define ISR_MASK_RST16     16'h0000
`endif

// File: hdl/isr_pkg.sv
// types of the instrument status reporting block
package isr_pkg;
	typedef enum logic [2:0]
	{
		ISR_CMD_NONE  = 3'h0,
		ISR_CMD_CLS   = 3'h1,
		ISR_CMD_PRESET = 3'h2,
		ISR_CMD_OPC   = 3'h3,
		ISR_CMD_OPCQ  = 3'h4
	} isr_cmd_type;
	typedef enum logic [1:0]
	{
		ISR_ST_IDLE = 2'b01,
		ISR_ST_WAIT = 2'b10
	} isr_opc_type;
endpackage

// File: hdl/isr_err_queue.sv
// oldest-first error message queue in flip-flops
`timescale 1ns/10ps
`default_nettype none
`include "isr_params.svh"
module isr_err_queue
	import isr_pkg::*;
#(
	parameter int DEPTH = `ISR_ERR_DEPTH,
	parameter int WIDTH = 8 * `ISR_ERR_CHARS
)
(
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] push_data_i,
	input  wire logic             pop_i,
	input  wire logic             clear_i,
	output logic      [WIDTH-1:0] head_o,
	output logic                  nonempty_o,
	output logic                  full_o
);
	localparam int AW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    rd_q;
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    cnt_q;
	logic             do_push;
	logic             do_pop;

	// a full queue drops new entries so the oldest ones survive
	assign do_push = push_i && (cnt_q != AW'(DEPTH));
	assign do_pop  = pop_i && (cnt_q != '0);

	// storage by index
	always_ff @(posedge clk_i)
	begin
		if (do_push)
			mem_q[wr_q] <= push_data_i;
	end

	// pointers and fill count
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rd_q  <= '0;
			wr_q  <= '0;
			cnt_q <= '0;
		end
		else if (clear_i)
		begin
			rd_q  <= '0;
			wr_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (do_push)
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			if (do_pop)
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			if (do_push && !do_pop)
				cnt_q <= cnt_q + 1'b1;
			else if (do_pop && !do_push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	assign head_o     = mem_q[rd_q];
	assign nonempty_o = (cnt_q != '0);
	assign full_o     = (cnt_q == AW'(DEPTH));

	a_queue_bound: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		cnt_q <= AW'(DEPTH))
		else $error("error queue count above depth");
endmodule
`default_nettype wire

// File: hdl/isr_status_core.sv
// status byte, event registers, masks and error queue of the instrument
//
// Function
// - error queue holds up to 20 entries, read back oldest first
// - each error entry holds up to 80 characters of text
// - quality enable mask selects quality events into the status byte
// - quality enable mask reads back as its binary weighted value
// - quality event register reads back as weighted sum of set bits
// - status preset clears only the quality enable mask
// - clear status zeroes the status summary and all event registers
// - standard event enable mask selects events into the status byte
// - standard event enable mask reads back as its weighted value
// - standard event register reads back as weighted sum of set bits
// - operation complete command sets event bit 0 once finished
// - operation complete query returns one once finished
// - power-on clear setting clears or keeps standard event and status byte masks, persists itself
// - power-on clear query returns the setting in effect
// - status byte enable mask selects enabled summary bits
// - status byte enable mask reads back as its weighted value
// - status byte query matches serial poll but leaves request bit
// - standard event bit meanings; bits 1 and 6 always zero
// - quality event bit meanings; unused bits always zero
// - reading an event register clears it after returning value
// - overload sets device error and quality bit, no queue entry
`timescale 1ns/10ps
`default_nettype none
`include "isr_params.svh"
module isr_status_core
	import isr_pkg::*;
#(
	parameter int CHARS = `ISR_ERR_CHARS,
	parameter int DEPTH = `ISR_ERR_DEPTH
)
(
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	input  wire isr_cmd_type          cmd_i,
	input  wire logic                 busy_i,
	input  wire logic                 ese_wr_i,
	input  wire logic [7:0]           ese_data_i,
	input  wire logic                 sre_wr_i,
	input  wire logic [7:0]           sre_data_i,
	input  wire logic                 ques_en_wr_i,
	input  wire logic [15:0]          ques_en_data_i,
	input  wire logic                 psc_wr_i,
	input  wire logic                 psc_data_i,
	input  wire logic                 psc_nv_i,
	input  wire logic                 power_on_i,
	input  wire logic                 esr_read_i,
	input  wire logic                 ques_read_i,
	input  wire logic                 err_read_i,
	input  wire logic                 query_err_i,
	input  wire logic                 dev_err_i,
	input  wire logic                 exec_err_i,
	input  wire logic                 cmd_err_i,
	input  wire logic [8*CHARS-1:0]   err_text_i,
	input  wire logic                 ovld_volt_i,
	input  wire logic                 ovld_curr_i,
	input  wire logic                 ovld_ohms_i,
	input  wire logic                 limit_lo_i,
	input  wire logic                 limit_hi_i,
	input  wire logic                 msg_avail_i,
	output logic      [7:0]           esr_o,
	output logic      [7:0]           ese_o,
	output logic      [15:0]          ques_o,
	output logic      [15:0]          ques_en_o,
	output logic      [7:0]           sre_o,
	output logic      [7:0]           stb_o,
	output logic                      psc_o,
	output logic                      opc_reply_o,
	output logic      [8*CHARS-1:0]   err_head_o,
	output logic                      err_avail_o
);
	logic [7:0]  esr_q;
	logic [7:0]  ese_q;
	logic [15:0] ques_q;
	logic [15:0] ques_en_q;
	logic [7:0]  sre_q;
	logic [7:0]  stb_q;
	logic        psc_q;
	logic        opc_reply_q;
	logic        pwr_s1_q;
	logic        pwr_s2_q;
	logic        pwr_d_q;
	logic        boot_q;
	logic [7:0]  esr_set;
	logic [15:0] ques_set;
	logic        is_cls;
	logic        pwr_rise;
	logic        any_ovld;
	logic        err_push;
	logic        err_nonempty;
	logic [8*CHARS-1:0] err_head;
	logic [7:0]  stb_d;
	isr_opc_type opc_q;
	logic        opc_query_q;

	assign is_cls = (cmd_i == ISR_CMD_CLS);

	// power-on marker comes from a pin, so it is synchronised first
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pwr_s1_q <= 1'b0;
			pwr_s2_q <= 1'b0;
			pwr_d_q  <= 1'b0;
		end
		else
		begin
			pwr_s1_q <= power_on_i;
			pwr_s2_q <= pwr_s1_q;
			pwr_d_q  <= pwr_s2_q;
		end
	end
	assign pwr_rise = pwr_s2_q && !pwr_d_q;

	// operation complete waits until prior commands have finished
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			opc_q       <= ISR_ST_IDLE;
			opc_query_q <= 1'b0;
		end
		else
		begin
			case (opc_q)
			ISR_ST_IDLE:
				if (cmd_i == ISR_CMD_OPC || cmd_i == ISR_CMD_OPCQ)
				begin
					opc_q       <= ISR_ST_WAIT;
					opc_query_q <= (cmd_i == ISR_CMD_OPCQ);
				end
			ISR_ST_WAIT:
				if (!busy_i)
					opc_q <= ISR_ST_IDLE;
			default:
				opc_q <= ISR_ST_IDLE;
			endcase
		end
	end

	// reply of one for the query form, pulsed at completion
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			opc_reply_q <= 1'b0;
		else
			opc_reply_q <= (opc_q == ISR_ST_WAIT) && !busy_i
				&& opc_query_q;
	end

	// overloads also flag device error but never enter the queue
	assign any_ovld = ovld_volt_i | ovld_curr_i | ovld_ohms_i;

	// standard event set terms; bits 1 and 6 have no source
	always_comb
	begin
		esr_set = 8'h00;
		esr_set[`ISR_ESR_OPC] = (opc_q == ISR_ST_WAIT) && !busy_i
			&& !opc_query_q;
		esr_set[`ISR_ESR_QYE] = query_err_i;
		esr_set[`ISR_ESR_DDE] = dev_err_i | any_ovld;
		esr_set[`ISR_ESR_EXE] = exec_err_i;
		esr_set[`ISR_ESR_CME] = cmd_err_i;
		esr_set[`ISR_ESR_PON] = pwr_rise;
		esr_set = esr_set & `ISR_ESR_VALID;
	end

	// quality event set terms on defined positions only
	always_comb
	begin
		ques_set = 16'h0000;
		ques_set[`ISR_QUES_VOLT] = ovld_volt_i;
		ques_set[`ISR_QUES_CURR] = ovld_curr_i;
		ques_set[`ISR_QUES_OHMS] = ovld_ohms_i;
		ques_set[`ISR_QUES_LO]   = limit_lo_i;
		ques_set[`ISR_QUES_HI]   = limit_hi_i;
		ques_set = ques_set & `ISR_QUES_VALID;
	end

	// sticky standard events; a new event wins over a read clear
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			esr_q <= 8'h00;
		else if (is_cls || esr_read_i)
			esr_q <= esr_set;
		else
			esr_q <= esr_q | esr_set;
	end

	// sticky quality events, same clearing scheme
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ques_q <= 16'h0000;
		else if (is_cls || ques_read_i)
			ques_q <= ques_set;
		else
			ques_q <= ques_q | ques_set;
	end

	// power-on clear setting: reloaded from non-volatile copy at boot
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			psc_q  <= 1'b0;
			boot_q <= 1'b1;
		end
		else if (boot_q)
		begin
			psc_q  <= psc_nv_i;
			boot_q <= 1'b0;
		end
		else if (psc_wr_i)
			psc_q <= psc_data_i;
	end

	// masks; the reset state is kept so a setting of zero preserves them
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ese_q <= `ISR_MASK_RST8;
			sre_q <= `ISR_MASK_RST8;
		end
		else
		begin
			if (pwr_rise && psc_q)
			begin
				ese_q <= `ISR_MASK_RST8;
				sre_q <= `ISR_MASK_RST8;
			end
			if (ese_wr_i)
				ese_q <= ese_data_i;
			if (sre_wr_i)
				sre_q <= sre_data_i & ~(8'h01 << `ISR_STB_RQS);
		end
	end

	// quality enable: cleared at power-up regardless of setting
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ques_en_q <= `ISR_MASK_RST16;
		else if (cmd_i == ISR_CMD_PRESET || pwr_rise)
			ques_en_q <= `ISR_MASK_RST16;
		else if (ques_en_wr_i)
			ques_en_q <= ques_en_data_i;
	end

	// error queue; overloads never push
	assign err_push = query_err_i | dev_err_i | exec_err_i | cmd_err_i;
	isr_err_queue #(
		.DEPTH (DEPTH),
		.WIDTH (8 * CHARS)
	) u_queue (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.push_i      (err_push),
		.push_data_i (err_text_i),
		.pop_i       (err_read_i),
		.clear_i     (is_cls),
		.head_o      (err_head),
		.nonempty_o  (err_nonempty),
		.full_o      ()
	);

	// summary from the updated event state, one clock behind the event registers
	always_comb
	begin
		stb_d = 8'h00;
		stb_d[`ISR_STB_EAV]  = err_nonempty;
		stb_d[`ISR_STB_QUES] = |(ques_q & ques_en_q);
		stb_d[`ISR_STB_MAV]  = msg_avail_i;
		stb_d[`ISR_STB_ESB]  = |(esr_q & ese_q);
		stb_d[`ISR_STB_RQS]  = |(stb_d & sre_q);
	end

	// query reads never clear the request bit
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			stb_q <= 8'h00;
		else if (is_cls)
			stb_q <= 8'h00;
		else
			stb_q <= stb_d;
	end

	// output copies from flip-flops
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			err_head_o  <= '0;
			err_avail_o <= 1'b0;
		end
		else
		begin
			err_head_o  <= err_head;
			err_avail_o <= err_nonempty;
		end
	end

	assign esr_o       = esr_q;
	assign ese_o       = ese_q;
	assign ques_o      = ques_q;
	assign ques_en_o   = ques_en_q;
	assign sre_o       = sre_q;
	assign stb_o       = stb_q;
	assign psc_o       = psc_q;
	assign opc_reply_o = opc_reply_q;

	a_esr_unused_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		esr_q[1] == 1'b0 && esr_q[6] == 1'b0)
		else $error("unused standard event bit set");
	a_ques_unused_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(ques_q & ~`ISR_QUES_VALID) == 16'h0000)
		else $error("unused quality bit set");
	a_cls_clears_all: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		is_cls && esr_set == 8'h00 && ques_set == 16'h0000
		|=> esr_q == 8'h00 && ques_q == 16'h0000 && stb_q == 8'h00)
		else $error("clear status left state");
	a_preset_only_quen: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		cmd_i == ISR_CMD_PRESET && !ese_wr_i && !sre_wr_i && !pwr_rise
		|=> ques_en_q == 16'h0000 && $stable(ese_q) && $stable(sre_q))
		else $error("preset misbehaved");
	a_ovld_sets_pair: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		ovld_ohms_i |=> esr_q[`ISR_ESR_DDE] && ques_q[`ISR_QUES_OHMS])
		else $error("overload not flagged in both");
	sequence s_opc_issue;
		opc_q == ISR_ST_IDLE && cmd_i == ISR_CMD_OPC;
	endsequence
	sequence s_opc_done;
		##1 (opc_q == ISR_ST_WAIT && !busy_i);
	endsequence
	a_opc_sets_bit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_opc_issue ##0 s_opc_done |=> esr_q[`ISR_ESR_OPC])
		else $error("operation complete bit not set");
	a_opcq_reply: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		opc_q == ISR_ST_WAIT && !busy_i && opc_query_q |=> opc_reply_q)
		else $error("operation complete reply missing");
	a_read_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		esr_read_i && esr_set == 8'h00 |=> esr_q == 8'h00)
		else $error("event read did not clear");
	a_rqs_summary: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!is_cls |=> stb_q[`ISR_STB_RQS]
		== |($past(stb_d) & $past(sre_q)))
		else $error("request bit mismatched");
	a_esb_summary: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!is_cls |=> stb_q[`ISR_STB_ESB] == |($past(esr_q) & $past(ese_q)))
		else $error("event summary mismatched");
	a_psc_keeps_mask: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		pwr_rise && !psc_q && !ese_wr_i |=> $stable(ese_q))
		else $error("mask cleared with setting zero");
endmodule
`default_nettype wire

// File: verification/isr_remote_ctrl.sv
// remote controller model: commands, mask writes and queries
`timescale 1ns/10ps
`default_nettype none
module isr_remote_ctrl
	import isr_pkg::*;
(
	input  wire logic       clk_i,
	output var isr_cmd_type cmd_o,
	output logic            ese_wr_o,
	output logic [7:0]      ese_data_o,
	output logic            sre_wr_o,
	output logic [7:0]      sre_data_o,
	output logic            ques_en_wr_o,
	output logic [15:0]     ques_en_data_o,
	output logic            psc_wr_o,
	output logic            psc_data_o,
	output logic            esr_read_o,
	output logic            ques_read_o,
	output logic            err_read_o
);
	logic [3:0]  wr_q;
	logic [2:0]  rd_q;
	logic [15:0] wd_q;

	// one strobe per request, one data word shared by all mask writes
	assign {psc_wr_o, ques_en_wr_o, sre_wr_o, ese_wr_o} = wr_q;
	assign {err_read_o, ques_read_o, esr_read_o} = rd_q;
	assign ese_data_o     = wd_q[7:0];
	assign sre_data_o     = wd_q[7:0];
	assign ques_en_data_o = wd_q;
	assign psc_data_o     = wd_q[0];

	initial
	begin
		cmd_o = ISR_CMD_NONE;
		wr_q  = 4'h0;
		rd_q  = 3'h0;
		wd_q  = 16'h0000;
	end

	// one-cycle request; released data shows the inverse so that a
	// stale value can never pass for a fresh one
	task automatic access(input isr_cmd_type c, input logic [3:0] w,
		input logic [2:0] r, input logic [15:0] d);
		@(posedge clk_i);
		#1;
		cmd_o = c;
		wr_q  = w;
		rd_q  = r;
		wd_q  = d;
		@(posedge clk_i);
		#1;
		cmd_o = ISR_CMD_NONE;
		wr_q  = 4'h0;
		rd_q  = 3'h0;
		wd_q  = ~d;
	endtask
endmodule
`default_nettype wire

// File: verification/instrument_status_reporting_bench.sv
// self-checking bench for the status reporting core
`timescale 1ns/10ps
`default_nettype none
`include "isr_params.svh"
module instrument_status_reporting_bench
	import isr_pkg::*;
	;
	localparam int TW = 8 * `ISR_ERR_CHARS;
	logic          clk_i, reset_n_i, busy_i, psc_nv_i, power_on_i;
	logic          ese_wr_i, sre_wr_i, ques_en_wr_i, psc_wr_i, psc_data_i;
	logic          esr_read_i, ques_read_i, err_read_i, msg_avail_i;
	logic          psc_o, opc_reply_o, err_avail_o;
	logic [7:0]    ese_data_i, sre_data_i, esr_o, ese_o, sre_o, stb_o;
	logic [15:0]   ques_en_data_i, ques_o, ques_en_o;
	logic [TW-1:0] err_text_i, err_head_o;
	logic [8:0]    ev;
	isr_cmd_type   cmd_i;
	int            fail_count, num_checks, n;

	isr_remote_ctrl u_isr_remote_ctrl
	(
		.clk_i(clk_i), .cmd_o(cmd_i), .ese_wr_o(ese_wr_i),
		.ese_data_o(ese_data_i), .sre_wr_o(sre_wr_i),
		.sre_data_o(sre_data_i), .ques_en_wr_o(ques_en_wr_i),
		.ques_en_data_o(ques_en_data_i), .psc_wr_o(psc_wr_i),
		.psc_data_o(psc_data_i), .esr_read_o(esr_read_i),
		.ques_read_o(ques_read_i), .err_read_o(err_read_i)
	);

	// event pulses: query, device, execution, command, overloads, then limits
	isr_status_core u_isr_status_core
	(
		.clk_i, .reset_n_i, .cmd_i, .busy_i, .ese_wr_i, .ese_data_i,
		.sre_wr_i, .sre_data_i, .ques_en_wr_i, .ques_en_data_i,
		.psc_wr_i, .psc_data_i, .psc_nv_i, .power_on_i, .esr_read_i,
		.ques_read_i, .err_read_i, .query_err_i(ev[8]),
		.dev_err_i(ev[7]), .exec_err_i(ev[6]), .cmd_err_i(ev[5]),
		.err_text_i, .ovld_volt_i(ev[4]), .ovld_curr_i(ev[3]),
		.ovld_ohms_i(ev[2]), .limit_lo_i(ev[1]), .limit_hi_i(ev[0]),
		.msg_avail_i, .esr_o, .ese_o, .ques_o, .ques_en_o, .sre_o,
		.stb_o, .psc_o, .opc_reply_o, .err_head_o, .err_avail_o
	);

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// first and last characters differ so the full text width counts
	function automatic logic [TW-1:0] txt(input int i);
		return {8'(8'h41 + i), {`ISR_ERR_CHARS - 2{8'h2e}}, 8'(8'h61 + i)};
	endfunction

	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask

	task automatic cmd(input isr_cmd_type c);
		u_isr_remote_ctrl.access(c, 4'h0, 3'h0, 16'h0000);
	endtask

	task automatic wr(input logic [3:0] w, input logic [15:0] d);
		u_isr_remote_ctrl.access(ISR_CMD_NONE, w, 3'h0, d);
	endtask

	task automatic rd(input logic [2:0] r);
		u_isr_remote_ctrl.access(ISR_CMD_NONE, 4'h0, r, 16'h0000);
	endtask

	task automatic pulse(input logic [8:0] e);
		@(posedge clk_i);
		#1;
		ev = e;
		@(posedge clk_i);
		#1;
		ev = 9'h000;
	endtask

	task automatic note(input bit bad, input logic [15:0] g, e);
		num_checks++;
		if (bad)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			fail_count++;
		end
	endtask

	task automatic chk1(input logic g, input logic e);
		note(g !== e, {15'h0000, g}, {15'h0000, e});
	endtask

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		note(g !== e, {8'h00, g}, {8'h00, e});
	endtask

	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		note(g !== e, g, e);
	endtask

	// text mismatches report only the low word to keep lines short
	task automatic chkt(input logic [TW-1:0] g, input logic [TW-1:0] e);
		note(g !== e, g[15:0], e[15:0]);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (5000) @(posedge clk_i);
		fail_count++;
		final_report();
	end

	initial
	begin
		fail_count  = 0;
		num_checks  = 0;
		ev          = 9'h000;
		err_text_i  = '0;
		busy_i      = 1'b0;
		psc_nv_i    = 1'b1;
		power_on_i  = 1'b0;
		msg_avail_i = 1'b0;
		reset_n_i   = 1'b0;
		tick(4);
		reset_n_i = 1'b1;
		tick(2);
		chk1(psc_o, 1'b1);
		chk8(ese_o, 8'h00);
		$display("test reset done");
		// one push more than the queue holds; the last must be dropped
		for (int i = 0; i < 21; i++)
		begin
			err_text_i = txt(i);
			ev = 9'h100;
			tick(1);
		end
		ev = 9'h000;
		tick(2);
		for (int i = 0; i < 20; i++)
		begin
			chkt(err_head_o, txt(i));
			rd(3'h4);
			tick(1);
		end
		chk1(err_avail_o, 1'b0);
		chk8(esr_o, 8'h04);
		rd(3'h1);
		chk8(esr_o, 8'h00);
		$display("test error queue done");
		wr(4'h1, 16'h00bd);
		chk8(ese_o, 8'hbd);
		wr(4'h2, 16'h00ff);
		chk8(sre_o, 8'hbf);
		wr(4'h4, 16'h1a03);
		chk16(ques_en_o, 16'h1a03);
		$display("test masks done");
		pulse(9'h1ff);
		chk8(esr_o, 8'h3c);
		chk16(ques_o, 16'h1a03);
		tick(2);
		chk8(stb_o, 8'h6c);
		tick(2);
		chk8(stb_o, 8'h6c);
		msg_avail_i = 1'b1;
		tick(3);
		chk8(stb_o, 8'h7c);
		msg_avail_i = 1'b0;
		rd(3'h2);
		chk16(ques_o, 16'h0000);
		tick(2);
		chk8(stb_o, 8'h64);
		$display("test summary done");
		cmd(ISR_CMD_PRESET);
		chk16(ques_en_o, 16'h0000);
		chk8(ese_o, 8'hbd);
		rd(3'h1);
		// drain the queue so an overload can be seen not to add to it
		for (int k = 0; k < 25; k++)
		begin
			if (err_avail_o === 1'b1)
				rd(3'h4);
			tick(1);
		end
		pulse(9'h004);
		chk8(esr_o, 8'h08);
		chk16(ques_o, 16'h0200);
		tick(2);
		chk1(err_avail_o, 1'b0);
		chk8(stb_o, 8'h60);
		cmd(ISR_CMD_CLS);
		chk8(esr_o, 8'h00);
		chk16(ques_o, 16'h0000);
		tick(2);
		chk8(stb_o, 8'h00);
		$display("test preset and clear done");
		busy_i = 1'b1;
		cmd(ISR_CMD_OPC);
		tick(3);
		chk8(esr_o, 8'h00);
		busy_i = 1'b0;
		tick(3);
		chk8(esr_o, 8'h01);
		busy_i = 1'b1;
		cmd(ISR_CMD_OPCQ);
		n = 0;
		for (int k = 0; k < 8; k++)
		begin
			if (k == 3)
				busy_i = 1'b0;
			if (opc_reply_o === 1'b1)
				n++;
			tick(1);
		end
		chk8(8'(n), 8'h01);
		$display("test operation complete done");
		wr(4'h8, 16'h0000);
		chk1(psc_o, 1'b0);
		wr(4'h4, 16'h1a03);
		power_on_i = 1'b1;
		tick(5);
		chk8(ese_o, 8'hbd);
		chk8(sre_o, 8'hbf);
		chk16(ques_en_o, 16'h0000);
		chk8(esr_o & 8'h80, 8'h80);
		power_on_i = 1'b0;
		tick(3);
		wr(4'h8, 16'h0001);
		chk1(psc_o, 1'b1);
		power_on_i = 1'b1;
		tick(5);
		chk8(ese_o, 8'h00);
		chk8(sre_o, 8'h00);
		$display("test power-on clear done");
		final_report();
	end
endmodule
`default_nettype wire
